// ===== pkg/dbot_pkg.sv
package dbot_pkg;

    localparam int DQ_W = 16;
    localparam int BA_W = 3;
    localparam int AD_W = 14;
    localparam int COL_W = 4;
    localparam int MEM_D = 16;
    localparam int RB_D = 8;
    localparam int BANKS = 8;
    localparam int ADDR_AP = 10;
    localparam int ADDR_BC = 12;

    // Latencies in link clock cycles
    localparam int CL = 5;
    localparam int CWL = 5;
    localparam int AL = 0;
    localparam logic [4:0] WL_CYC = 5'(AL + CWL);
    localparam logic [4:0] RL_CYC = 5'(AL + CL);
    localparam logic [4:0] ANPD_CYC = 5'(AL + CWL - 1);
    localparam logic [4:0] RD_SLACK = 5'h4;

    // Controller link clock is the system clock divided by two
    localparam int SYS_NS = 10;
    localparam int CK_NS = 2 * SYS_NS;
    localparam int T_WTR_NS = 8;
    localparam int T_WR_NS = 15;
    localparam int T_RAS_NS = 35;
    localparam int T_RC_NS = 49;
    localparam logic [4:0] T_WTR_CK = 5'((T_WTR_NS + CK_NS - 1) / CK_NS);
    localparam logic [4:0] T_WR_CK = 5'((T_WR_NS + CK_NS - 1) / CK_NS);
    localparam logic [4:0] T_RAS_CK = 5'((T_RAS_NS + CK_NS - 1) / CK_NS);
    localparam logic [4:0] T_RC_CK = 5'((T_RC_NS + CK_NS - 1) / CK_NS);
    localparam logic [4:0] ODTH4 = 5'h4;
    localparam logic [4:0] ODTH8 = 5'h6;

    // Burst field of mode register 0
    localparam logic [1:0] BM_FIX8 = 2'h0;
    localparam logic [1:0] BM_OTF = 2'h1;
    localparam logic [1:0] BM_BC4 = 2'h2;
    localparam logic [3:0] BEATS8 = 4'h8;
    localparam logic [3:0] BEATS4 = 4'h4;

    // Pin command codes {ras_n, cas_n, we_n}
    localparam logic [2:0] CMD_MRS = 3'h0;
    localparam logic [2:0] CMD_PRE = 3'h2;
    localparam logic [2:0] CMD_ACT = 3'h3;
    localparam logic [2:0] CMD_WR = 3'h4;
    localparam logic [2:0] CMD_RD = 3'h5;
    localparam logic [2:0] CMD_NOP = 3'h7;

    // Controller order codes
    localparam logic [2:0] OP_MRS = 3'h0;
    localparam logic [2:0] OP_ACT = 3'h1;
    localparam logic [2:0] OP_RD = 3'h2;
    localparam logic [2:0] OP_WR = 3'h3;
    localparam logic [2:0] OP_PRE = 3'h4;
    localparam logic [2:0] OP_PDE = 3'h5;
    localparam logic [2:0] OP_PDX = 3'h6;

    // Controller register word offsets and fields
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_CMD = 4'h1;
    localparam logic [3:0] REG_WDATA = 4'h2;
    localparam logic [3:0] REG_STATUS = 4'h3;
    localparam int RDATA_SEL = 3;
    localparam int CTRL_ODT = 0;
    localparam int CMD_W = 22;
    localparam int CMD_A12 = 3;
    localparam int CMD_BA = 4;
    localparam int CMD_AD = 8;

    typedef enum logic [2:0] {
        S_IDLE = 3'h1,
        S_WR = 3'h2,
        S_RD = 3'h4
    } dbot_st_t;

    function automatic logic burst8(input logic [1:0] bm, input logic a12);
        return (bm == BM_FIX8) || ((bm == BM_OTF) && a12);
    endfunction

    function automatic logic [3:0] burst_beats(input logic [1:0] bm, input logic a12);
        return burst8(bm, a12) ? BEATS8 : BEATS4;
    endfunction

    function automatic logic [4:0] dec5(input logic [4:0] v);
        return (v != 5'h0) ? v - 5'h1 : 5'h0;
    endfunction

    function automatic logic [4:0] max5(input logic [4:0] a, input logic [4:0] b);
        return (a > b) ? a : b;
    endfunction

endpackage

// ===== pkg/dbot_if.sv
`timescale 1ns/1ps
interface dbot_if
    import dbot_pkg::*;
();
    logic ck;
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic odt;
    logic [BA_W-1:0] ba;
    logic [AD_W-1:0] addr;
    logic [DQ_W-1:0] dq_c;
    logic [DQ_W-1:0] dq_d;
    logic [DQ_W-1:0] dq;
    logic dqs_c;
    logic dqs_d;
    logic dqs;
    logic c_oe_n;
    logic d_oe_n;

    // Wire level of the shared data and strobe lines
    assign dq = !c_oe_n ? dq_c : (!d_oe_n ? dq_d : '0);
    assign dqs = !c_oe_n ? dqs_c : (!d_oe_n ? dqs_d : 1'b0);

    modport ctl (
        output ck, cke, cs_n, ras_n, cas_n, we_n, odt, ba, addr, dq_c, dqs_c, c_oe_n,
        input dq, dqs
    );
    modport dev (
        input ck, cke, cs_n, ras_n, cas_n, we_n, odt, ba, addr, dq, dqs,
        output dq_d, dqs_d, d_oe_n
    );
endinterface

// ===== verilog/dbot_dev.sv
`timescale 1ns/1ps
module dbot_dev
    import dbot_pkg::*;
(
    dbot_if.dev lnk,
    input wire logic dev_rst_i,
    output logic [BANKS-1:0] bank_open_o,
    output logic act_pd_o,
    output logic pre_pd_o,
    output logic odt_sync_o,
    output logic odt_err_o,
    output logic last_bl8_o
);
    logic issue;
    logic [2:0] cmd;
    logic [3:0] beats;
    logic wcap;
    logic rcap;
    logic [1:0] mode_r;
    logic [BANKS-1:0] open_r;
    logic [DQ_W-1:0] mem_r [MEM_D];
    logic [4:0] wdly_r;
    logic [3:0] wleft_r;
    logic [COL_W-1:0] wcol_r;
    logic [4:0] rdly_r;
    logic [3:0] rleft_r;
    logic [COL_W-1:0] rcol_r;
    logic [DQ_W-1:0] dq_r;
    logic dqs_r;
    logic oe_n_r;
    logic pd_r;
    logic pdact_r;
    logic [4:0] anpd_r;
    logic odt_q_r;
    logic [4:0] odth_r;
    logic err_r;
    logic bl8_r;

    assign issue = lnk.cke & ~lnk.cs_n;
    assign cmd = {lnk.ras_n, lnk.cas_n, lnk.we_n};
    assign beats = burst_beats(mode_r, lnk.addr[ADDR_BC]);
    assign wcap = (wleft_r != 4'h0) && (wdly_r <= 5'h1);
    assign rcap = (rleft_r != 4'h0) && (rdly_r <= 5'h1);

    always_ff @(posedge lnk.ck or posedge dev_rst_i)
    begin
        if (dev_rst_i)
            mode_r <= BM_FIX8;
        else if (issue && cmd == CMD_MRS && lnk.ba == '0)
            mode_r <= lnk.addr[1:0];
    end

    always_ff @(posedge lnk.ck or posedge dev_rst_i)
    begin
        if (dev_rst_i)
            open_r <= '0;
        else if (issue && cmd == CMD_ACT)
            open_r[lnk.ba] <= 1'b1;
        else if (issue && cmd == CMD_PRE)
        begin
            if (lnk.addr[ADDR_AP])
                open_r <= '0;
            else
                open_r[lnk.ba] <= 1'b0;
        end
    end

    always_ff @(posedge lnk.ck or posedge dev_rst_i)
    begin
        if (dev_rst_i)
            bl8_r <= 1'b0;
        else if (issue && (cmd == CMD_WR || cmd == CMD_RD))
            bl8_r <= (beats == BEATS8);
    end

    // Write path: first beat taken WL clocks after the command
    always_ff @(posedge lnk.ck or posedge dev_rst_i)
    begin
        if (dev_rst_i)
        begin
            wdly_r <= 5'h0;
            wleft_r <= 4'h0;
            wcol_r <= '0;
        end
        else if (issue && cmd == CMD_WR)
        begin
            wdly_r <= WL_CYC;
            wleft_r <= beats;
            wcol_r <= lnk.addr[COL_W-1:0];
        end
        else if (wleft_r != 4'h0)
        begin
            wdly_r <= dec5(wdly_r);
            if (wcap)
            begin
                wleft_r <= wleft_r - 4'h1;
                wcol_r <= wcol_r + COL_W'(1);
            end
        end
    end

    always_ff @(posedge lnk.ck)
    begin
        if (wcap)
            mem_r[wcol_r] <= lnk.dq;
    end

    // Read path: first beat driven RL clocks after the command
    always_ff @(posedge lnk.ck or posedge dev_rst_i)
    begin
        if (dev_rst_i)
        begin
            rdly_r <= 5'h0;
            rleft_r <= 4'h0;
            rcol_r <= '0;
        end
        else if (issue && cmd == CMD_RD)
        begin
            rdly_r <= RL_CYC;
            rleft_r <= beats;
            rcol_r <= lnk.addr[COL_W-1:0];
        end
        else if (rleft_r != 4'h0)
        begin
            rdly_r <= dec5(rdly_r);
            if (rcap)
            begin
                rleft_r <= rleft_r - 4'h1;
                rcol_r <= rcol_r + COL_W'(1);
            end
        end
    end

    always_ff @(posedge lnk.ck or posedge dev_rst_i)
    begin
        if (dev_rst_i)
        begin
            dq_r <= '0;
            dqs_r <= 1'b0;
            oe_n_r <= 1'b1;
        end
        else if (rcap)
        begin
            dq_r <= mem_r[rcol_r];
            dqs_r <= ~dqs_r;
            oe_n_r <= 1'b0;
        end
        else
            oe_n_r <= 1'b1;
    end

    // Power-down type and ODT transition period on exit from precharge power-down
    always_ff @(posedge lnk.ck or posedge dev_rst_i)
    begin
        if (dev_rst_i)
        begin
            pd_r <= 1'b0;
            pdact_r <= 1'b0;
            anpd_r <= 5'h0;
        end
        else if (!pd_r && !lnk.cke)
        begin
            pd_r <= 1'b1;
            pdact_r <= |open_r;
        end
        else if (pd_r && lnk.cke)
        begin
            pd_r <= 1'b0;
            anpd_r <= pdact_r ? 5'h0 : ANPD_CYC;
        end
        else
            anpd_r <= dec5(anpd_r);
    end

    // ODT hold watch, from first high or from a write with ODT high
    always_ff @(posedge lnk.ck or posedge dev_rst_i)
    begin
        if (dev_rst_i)
        begin
            odt_q_r <= 1'b0;
            odth_r <= 5'h0;
            err_r <= 1'b0;
        end
        else
        begin
            odt_q_r <= lnk.odt;
            if (lnk.odt && issue && cmd == CMD_WR)
                odth_r <= max5(dec5(odth_r), (beats == BEATS8) ? ODTH8 : ODTH4);
            else if (lnk.odt && !odt_q_r)
                odth_r <= ODTH4;
            else
                odth_r <= dec5(odth_r);
            if (!lnk.odt && odt_q_r && odth_r > 5'h1)
                err_r <= 1'b1;
        end
    end

    assign lnk.dq_d = dq_r;
    assign lnk.dqs_d = dqs_r;
    assign lnk.d_oe_n = oe_n_r;
    assign bank_open_o = open_r;
    assign act_pd_o = pd_r & pdact_r;
    assign pre_pd_o = pd_r & ~pdact_r;
    assign odt_sync_o = ~pd_r & (anpd_r == 5'h0);
    assign odt_err_o = err_r;
    assign last_bl8_o = bl8_r;
endmodule

// ===== verilog/dbot_ctl.sv
// The Avalon-MM slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module dbot_ctl
    import dbot_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    dbot_if.ctl lnk
);
    dbot_st_t state_r;
    logic ck_r;
    logic tick;
    logic req;
    logic hold;
    logic ack_r;
    logic ack_nxt;
    logic accept;
    logic [31:0] rd_mux;
    logic [31:0] rdata_r;
    logic odt_en_r;
    logic [CMD_W-1:0] cmd_r;
    logic pend_r;
    logic [DQ_W-1:0] wdata_r;
    logic [DQ_W-1:0] rbuf_r [RB_D];
    logic [2:0] ridx_r;
    logic [2:0] op;
    logic a12;
    logic issue_ok;
    logic go;
    logic [1:0] mode_r;
    logic [3:0] beats_r;
    logic [4:0] blc;
    logic [4:0] cyc_r;
    logic [4:0] cyc_nxt;
    logic wr_end;
    logic [4:0] ras_r;
    logic [4:0] rc_r;
    logic [4:0] wr_r;
    logic [4:0] wtr_r;
    logic [4:0] odt_cnt_r;
    logic odt_r;
    logic cke_r;
    logic cs_n_r;
    logic [2:0] pcmd_r;
    logic [BA_W-1:0] ba_r;
    logic [AD_W-1:0] addr_r;
    logic [DQ_W-1:0] dq_r;
    logic dqs_r;
    logic oe_n_r;
    logic dqs_prev_r;

    // Link clock is sys_clk_i divided by two; tick marks its falling edge
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            ck_r <= 1'b0;
        else
            ck_r <= ~ck_r;
    end
    assign tick = ck_r;

    // Avalon slave: one wait cycle, longer for an order while one is pending
    assign req = avs_read_i | avs_write_i;
    assign hold = avs_write_i && (avs_address_i == REG_CMD) && pend_r;
    assign ack_nxt = req & ~ack_r & ~hold;
    assign accept = req & ack_r;
    assign avs_waitrequest_o = req & ~ack_r;

    always_comb
    begin
        rd_mux = 32'h0;
        if (avs_address_i[RDATA_SEL])
            rd_mux[DQ_W-1:0] = rbuf_r[avs_address_i[2:0]];
        else
        begin
            case (avs_address_i)
                REG_CTRL: rd_mux[CTRL_ODT] = odt_en_r;
                REG_CMD: rd_mux[CMD_W-1:0] = cmd_r;
                REG_WDATA: rd_mux[DQ_W-1:0] = wdata_r;
                REG_STATUS: rd_mux[4:0] = {odt_r, mode_r, ~cke_r,
                    pend_r | (state_r != S_IDLE)};
                default: rd_mux = 32'h0;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            ack_r <= 1'b0;
            rdata_r <= 32'h0;
        end
        else
        begin
            ack_r <= ack_nxt;
            if (ack_nxt)
                rdata_r <= rd_mux;
        end
    end
    assign avs_readdata_o = rdata_r;

    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            odt_en_r <= 1'b0;
            cmd_r <= '0;
            wdata_r <= '0;
            pend_r <= 1'b0;
        end
        else
        begin
            if (go)
                pend_r <= 1'b0;
            if (accept && avs_write_i)
            begin
                case (avs_address_i)
                    REG_CTRL: odt_en_r <= avs_writedata_i[CTRL_ODT];
                    REG_CMD:
                    begin
                        cmd_r <= avs_writedata_i[CMD_W-1:0];
                        pend_r <= 1'b1;
                    end
                    REG_WDATA: wdata_r <= avs_writedata_i[DQ_W-1:0];
                    default: pend_r <= pend_r;
                endcase
            end
        end
    end

    // Order issue, gated by bank and write timing
    assign op = cmd_r[2:0];
    assign a12 = cmd_r[CMD_A12];
    always_comb
    begin
        case (op)
            OP_PRE: issue_ok = (ras_r == 5'h0) && (wr_r == 5'h0);
            OP_ACT: issue_ok = (rc_r == 5'h0);
            OP_RD: issue_ok = (wtr_r == 5'h0);
            default: issue_ok = 1'b1;
        endcase
    end
    assign go = tick & pend_r & (state_r == S_IDLE) & issue_ok;

    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            cke_r <= 1'b1;
            cs_n_r <= 1'b1;
            pcmd_r <= CMD_NOP;
            ba_r <= '0;
            addr_r <= '0;
        end
        else if (tick)
        begin
            cs_n_r <= 1'b1;
            pcmd_r <= CMD_NOP;
            if (go)
            begin
                ba_r <= cmd_r[CMD_BA+BA_W-1:CMD_BA];
                addr_r <= cmd_r[CMD_AD+AD_W-1:CMD_AD];
                if (op == OP_RD || op == OP_WR)
                    addr_r[ADDR_BC] <= a12;
                case (op)
                    OP_PDE: cke_r <= 1'b0;
                    OP_PDX: cke_r <= 1'b1;
                    default: cs_n_r <= 1'b0;
                endcase
                case (op)
                    OP_MRS: pcmd_r <= CMD_MRS;
                    OP_ACT: pcmd_r <= CMD_ACT;
                    OP_RD: pcmd_r <= CMD_RD;
                    OP_WR: pcmd_r <= CMD_WR;
                    OP_PRE: pcmd_r <= CMD_PRE;
                    default: pcmd_r <= CMD_NOP;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            mode_r <= BM_FIX8;
        else if (go && op == OP_MRS && cmd_r[CMD_BA+BA_W-1:CMD_BA] == '0)
            mode_r <= cmd_r[CMD_AD+1:CMD_AD];
    end

    // Transfer sequencing
    assign blc = {1'b0, beats_r};
    assign cyc_nxt = cyc_r + 5'h1;
    assign wr_end = tick && (state_r == S_WR) && (cyc_nxt == WL_CYC + blc);

    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            state_r <= S_IDLE;
            cyc_r <= 5'h0;
            beats_r <= BEATS8;
        end
        else if (tick)
        begin
            cyc_r <= cyc_nxt;
            case (state_r)
                S_IDLE:
                begin
                    cyc_r <= 5'h0;
                    if (go && (op == OP_RD || op == OP_WR))
                    begin
                        beats_r <= burst_beats(mode_r, a12);
                        state_r <= (op == OP_WR) ? S_WR : S_RD;
                    end
                end
                S_WR:
                    if (wr_end)
                        state_r <= S_IDLE;
                S_RD:
                    if (cyc_nxt == RL_CYC + blc + RD_SLACK)
                        state_r <= S_IDLE;
                default: state_r <= S_IDLE;
            endcase
        end
    end

    // Write beats placed WL link cycles after the command
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            dq_r <= '0;
            dqs_r <= 1'b0;
            oe_n_r <= 1'b1;
        end
        else if (tick)
        begin
            if (state_r == S_WR && cyc_nxt >= WL_CYC && cyc_nxt < WL_CYC + blc)
            begin
                dq_r <= wdata_r + DQ_W'(cyc_nxt - WL_CYC);
                dqs_r <= ~dqs_r;
                oe_n_r <= 1'b0;
            end
            else
                oe_n_r <= 1'b1;
        end
    end

    // Read beats caught on each strobe change
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            dqs_prev_r <= 1'b0;
            ridx_r <= 3'h0;
            for (int i = 0; i < RB_D; i++)
                rbuf_r[i] <= '0;
        end
        else if (tick)
        begin
            dqs_prev_r <= lnk.dqs;
            if (go && op == OP_RD)
                ridx_r <= 3'h0;
            else if (state_r == S_RD && lnk.dqs != dqs_prev_r)
            begin
                rbuf_r[ridx_r] <= lnk.dq;
                ridx_r <= ridx_r + 3'h1;
            end
        end
    end

    // Bank and write recovery timers, counted in link cycles
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            ras_r <= 5'h0;
            rc_r <= 5'h0;
            wr_r <= 5'h0;
            wtr_r <= 5'h0;
        end
        else if (tick)
        begin
            ras_r <= (go && op == OP_ACT) ? T_RAS_CK : dec5(ras_r);
            rc_r <= (go && op == OP_ACT) ? T_RC_CK : dec5(rc_r);
            wr_r <= wr_end ? T_WR_CK : dec5(wr_r);
            wtr_r <= wr_end ? T_WTR_CK : dec5(wtr_r);
        end
    end

    // Termination: raised with a write, held until the write ends and the longer of both holds runs out
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            odt_r <= 1'b0;
            odt_cnt_r <= 5'h0;
        end
        else if (tick)
        begin
            if (go && op == OP_WR && odt_en_r)
            begin
                odt_r <= 1'b1;
                odt_cnt_r <= max5(dec5(odt_cnt_r),
                    burst8(mode_r, a12) ? ODTH8 : ODTH4);
            end
            else
            begin
                odt_cnt_r <= dec5(odt_cnt_r);
                if (odt_r && odt_cnt_r <= 5'h1 && state_r != S_WR)
                    odt_r <= 1'b0;
            end
        end
    end

    assign lnk.ck = ck_r;
    assign lnk.cke = cke_r;
    assign lnk.cs_n = cs_n_r;
    assign lnk.ras_n = pcmd_r[2];
    assign lnk.cas_n = pcmd_r[1];
    assign lnk.we_n = pcmd_r[0];
    assign lnk.ba = ba_r;
    assign lnk.addr = addr_r;
    assign lnk.odt = odt_r;
    assign lnk.dq_c = dq_r;
    assign lnk.dqs_c = dqs_r;
    assign lnk.c_oe_n = oe_n_r;
endmodule

// ===== test/dbot_sva.sv
`timescale 1ns/1ps
module dbot_sva
    import dbot_pkg::*;
(
    input wire logic ck,
    input wire logic sys_rst_i,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic odt,
    input wire logic [BA_W-1:0] ba,
    input wire logic [AD_W-1:0] addr,
    input wire logic c_oe_n,
    input wire logic d_oe_n
);
    logic [1:0] bm_r;
    wire logic [2:0] cmd = cs_n ? CMD_NOP : {ras_n, cas_n, we_n};
    wire logic b8 = (bm_r == BM_FIX8) || (bm_r == BM_OTF && addr[ADDR_BC]);
    wire logic wr = cmd == CMD_WR;
    wire logic rd = cmd == CMD_RD;

    // Burst field as last set by the controller
    always_ff @(posedge ck or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            bm_r <= BM_FIX8;
        else if (cmd == CMD_MRS && ba == '0)
            bm_r <= addr[1:0];
    end

    default clocking @(posedge ck); endclocking
    default disable iff (sys_rst_i);

    a_wr_bl8: assert property (wr && b8 |-> ##5 !c_oe_n [*8]
        ##1 c_oe_n)
        else $error("write burst not eight beats");
    a_wr_bc4: assert property (wr && !b8 |-> ##5 !c_oe_n [*4]
        ##1 c_oe_n)
        else $error("write burst not four beats");
    a_rd_bl8: assert property (rd && b8 |-> ##[5:6] $fell(d_oe_n)
        ##0 !d_oe_n [*8] ##1 d_oe_n)
        else $error("read burst not eight beats");
    a_rd_bc4: assert property (rd && !b8 |-> ##[5:6] $fell(d_oe_n)
        ##0 !d_oe_n [*4] ##1 d_oe_n)
        else $error("read burst not four beats");
    a_wtr_gap: assert property ($rose(c_oe_n) |-> !rd)
        else $error("read too soon after write");
    a_wr_recovery: assert property ($rose(c_oe_n) |-> cmd != CMD_PRE)
        else $error("precharge too soon after write");
    a_row_cycle: assert property (cmd == CMD_ACT |=> cmd != CMD_PRE
        && cmd != CMD_ACT ##1 cmd != CMD_ACT)
        else $error("row timing broken");
    a_odt_hold: assert property ($rose(odt) |-> odt [*4])
        else $error("odt dropped early");
    a_odt_wr8: assert property (wr && odt && b8 |-> odt [*6])
        else $error("odt short after long write");
    a_odt_wr4: assert property (wr && odt && !b8 |-> odt [*4])
        else $error("odt short after chopped write");

    cover property (wr && !b8);
    cover property (rd && b8);
    cover property (wr && odt);
endmodule

// ===== test/tb_ddr3_burst_odt_timing.sv
`timescale 1ns/1ps
module tb_ddr3_burst_odt_timing
    import dbot_pkg::*;
;
    logic sys_clk_i = 1'b0;
    logic sys_rst_i = 1'b0;
    logic [3:0] avs_address_i = '0;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = '0;
    wire logic [31:0] avs_readdata_o;
    wire logic avs_waitrequest_o;
    wire logic [BANKS-1:0] bank_open_o;
    wire logic act_pd_o, pre_pd_o, odt_sync_o, odt_err_o, last_bl8_o, bad_err;
    int miscompares = 0;
    int n_tests = 0;
    int cycles = 0;
    logic [15:0] mem [8];
    logic [3:0] wbeats = '0;
    logic [31:0] v;
    dbot_if lnk_if();
    dbot_if bad_if();
    dbot_ctl dbot_ctl_i(.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .lnk(lnk_if));
    dbot_dev dbot_dev_i(.lnk(lnk_if), .dev_rst_i(sys_rst_i), .bank_open_o(bank_open_o),
        .act_pd_o(act_pd_o), .pre_pd_o(pre_pd_o), .odt_sync_o(odt_sync_o),
        .odt_err_o(odt_err_o), .last_bl8_o(last_bl8_o));
    dbot_dev dbot_dev_b_i(.lnk(bad_if), .dev_rst_i(sys_rst_i), .bank_open_o(),
        .act_pd_o(), .pre_pd_o(), .odt_sync_o(), .odt_err_o(bad_err), .last_bl8_o());
    dbot_sva dbot_sva_i(.ck(lnk_if.ck), .sys_rst_i(sys_rst_i), .cs_n(lnk_if.cs_n),
        .ras_n(lnk_if.ras_n), .cas_n(lnk_if.cas_n), .we_n(lnk_if.we_n), .odt(lnk_if.odt),
        .ba(lnk_if.ba), .addr(lnk_if.addr), .c_oe_n(lnk_if.c_oe_n), .d_oe_n(lnk_if.d_oe_n));

    always #(SYS_NS / 2) sys_clk_i = ~sys_clk_i;

    // Counts write beats on the wire
    always @(posedge lnk_if.ck)
        if (!lnk_if.cs_n && {lnk_if.ras_n, lnk_if.cas_n, lnk_if.we_n} == CMD_WR)
            wbeats <= 4'h0;
        else if (!lnk_if.c_oe_n)
            wbeats <= wbeats + 4'h1;

    always @(posedge sys_clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 60000)
        begin
            miscompares++;
            final_report();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic bus(input logic rw, input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= rw;
        avs_read_i <= !rw;
        do
            @(posedge sys_clk_i);
        while (avs_waitrequest_o !== 1'b0);
        v = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask

    task automatic order(input logic [2:0] op, input logic a12, input logic [13:0] ad);
        bus(1'b1, REG_CMD, {10'h000, ad, 4'h0, a12, op});
        do
            bus(1'b0, REG_STATUS, 32'h0);
        while (v[0] !== 1'b0);
    endtask

    task automatic t_burst;
        logic [3:0] n;
        bus(1'b1, REG_CTRL, 32'h1);
        order(OP_ACT, 1'b0, 14'h0);
        check(32'(bank_open_o), 32'h1);
        for (int m = 0; m < 6; m++)
        begin
            n = (m < 2 || m == 3) ? BEATS8 : BEATS4;
            order(OP_MRS, 1'b0, 14'(m / 2));
            bus(1'b0, REG_STATUS, 32'h0);
            check(32'(v[3:2]), 32'(m / 2));
            bus(1'b1, REG_WDATA, 32'(16'hA00 + 16'(m * 16)));
            order(OP_WR, m[0], 14'h0);
            check(32'(wbeats), 32'(n));
            for (int i = 0; i < n; i++)
                mem[i] = 16'(16'hA00 + m * 16 + i);
            order(OP_RD, m[0], 14'h0);
            check(32'(last_bl8_o), 32'(n == BEATS8));
            for (int i = 0; i < n; i++)
            begin
                bus(1'b0, 4'(8 + i), 32'h0);
                check(v, {16'h0, mem[i]});
            end
        end
        bus(1'b1, REG_CTRL, 32'h0);
        check(32'(odt_err_o), 32'h0);
        $display("burst test done");
    endtask

    task automatic t_power;
        int k;
        order(OP_PDE, 1'b0, 14'h0);
        check(32'({act_pd_o, pre_pd_o}), 32'h2);
        order(OP_PDX, 1'b0, 14'h0);
        order(OP_PRE, 1'b0, 14'h400);
        check(32'(bank_open_o), 32'h0);
        order(OP_PDE, 1'b0, 14'h0);
        check(32'({act_pd_o, pre_pd_o}), 32'h1);
        bus(1'b1, REG_CMD, 32'(OP_PDX));
        @(posedge lnk_if.ck iff lnk_if.cke === 1'b1);
        #1;
        k = 0;
        while (odt_sync_o !== 1'b1 && k < 40)
        begin
            @(posedge lnk_if.ck);
            #1;
            k++;
        end
        check(32'(k), 32'(ANPD_CYC));
        $display("power-down test done");
    endtask

    task automatic t_bad;
        for (int i = 0; i < 8; i++)
        begin
            bad_if.odt <= (i == 1 || i == 2);
            #6 bad_if.ck <= 1'b1;
            #6 bad_if.ck <= 1'b0;
        end
        check(32'(bad_err), 32'h1);
        $display("early odt drop test done");
    endtask

    task automatic final_report;
        $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial
    begin
        {bad_if.ck, bad_if.odt, bad_if.ba, bad_if.addr, bad_if.dq_c, bad_if.dqs_c} = '0;
        {bad_if.cke, bad_if.cs_n, bad_if.ras_n, bad_if.cas_n, bad_if.we_n} = 5'h1F;
        bad_if.c_oe_n = 1'b1;
        @(posedge sys_clk_i);
        sys_rst_i <= 1'b1;
        repeat (6) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        t_burst();
        t_power();
        t_bad();
        final_report();
    end
endmodule
